/* shared/pmc_pkg.sv */
package pmc_pkg;
  localparam logic [0:0] ADDR_FIRST = 1'h0;
  localparam logic [0:0] ADDR_SECOND = 1'h1;
  localparam logic [7:0] FIRST_RESET = 8'h07;
  localparam logic [7:0] SECOND_RESET = 8'he0;
  localparam logic [7:0] FIRST_WMASK = 8'hfb;
  localparam logic [7:0] SECOND_WMASK = 8'h1f;
  localparam logic [7:0] FIRST_FIXED = 8'h04;
  localparam logic [7:0] SECOND_FIXED = 8'he0;
  localparam int F_STBY = 7;
  localparam int F_STS_HI = 6;
  localparam int F_STS_LO = 4;
  localparam int F_LOW_SPEED_SELECT = 3;
  localparam int F_MA_HI = 1;
  localparam int F_MA_LO = 0;
  localparam int F_NOISE_SAMPLE_RATE_SELECT = 4;
  localparam int F_DIRECT_TRANSFER_ENABLE = 3;
  localparam int F_MEDIUM_SPEED_SELECT = 2;
  localparam int F_SA_HI = 1;
  localparam int F_SA_LO = 0;
  localparam int SETTLE_W = 17;
  localparam logic [16:0] SETTLE_BASE = 17'h02000;
  localparam int DIV_W = 8;
  localparam logic [7:0] MA_DIV0 = 8'h10;
  localparam logic [7:0] SA_DIV0 = 8'h08;
  localparam logic [7:0] NS_SLOW = 8'h10;
  localparam logic [7:0] NS_FAST = 8'h04;
  typedef enum logic [7:0] {
    PMC_ACT_HI = 8'h01,
    PMC_ACT_MED = 8'h02,
    PMC_SLP_HI = 8'h04,
    PMC_SLP_MED = 8'h08,
    PMC_SUBACT = 8'h10,
    PMC_SUBSLP = 8'h20,
    PMC_WATCH = 8'h40,
    PMC_STBY = 8'h80
  } pmc_mode_t;
endpackage

/* verilog/pmc_divider.sv */
`timescale 1ns/10ps
// Free-running tick generator; one pulse every div_val clocks.
module pmc_divider
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [DIV_W-1:0] div_val,
  output logic tick
);
  logic [DIV_W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_r <= 8'h00;
    end else if (cnt_r >= div_val - 8'h01) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  assign tick = (cnt_r == 8'h00);
endmodule

/* verilog/pmc_top.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - First register resets to 0x07.
// - Standby select clear: sleep or subsleep.
// - Standby select set: standby or watch.
// - Settle select picks wait of 8192..131072 states.
// - Low-speed select picks system or subclock.
// - First register bit 2 reads one.
// - Medium divider selects 16 to 128.
// - Second register resets to 0xe0.
// - Second register bits 7..5 read one.
// - Noise sample rate divides by 16 or 4.
// - Direct transfer from high-speed active.
// - Direct transfer from medium-speed active.
// - Direct transfer from subactive needs specific bits.
// - Wake resumes high or medium per medium select.
// - Sleep enters high or medium sleep.
// - Subactive divider selects 8, 4 or 2.
// - Subactive divider frozen in subactive mode.
// - Timer A bit chooses standby or watch.
// - Standby wake: restart oscillator, settle, then handle.
module pmc_top
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [0:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_req,
  input wire logic wake_irq,
  input wire logic timer_a_clock_select_bit,
  output logic [7:0] mode,
  output logic cpu_on_subclock,
  output logic sys_osc_enable,
  output logic cpu_halted,
  output logic settling,
  output logic exception_start,
  output logic medium_tick,
  output logic subactive_tick,
  output logic noise_sample_tick
);
  logic [7:0] first_r;
  logic [7:0] second_r;
  pmc_mode_t mode_r;
  pmc_mode_t mode_nxt;
  logic [SETTLE_W:0] settle_cnt_r;
  logic [SETTLE_W:0] settle_len;
  logic settle_r;
  logic exc_r;
  logic [7:0] rdata_r;
  logic stby, low_speed_select, medium_speed_select, direct_transfer_enable;
  logic [1:0] ma_sel;
  logic [1:0] sa_sel;
  logic [2:0] sts_sel;
  logic [DIV_W-1:0] ma_div;
  logic [DIV_W-1:0] sa_div;
  logic [DIV_W-1:0] ns_div;
  logic in_active;
  logic woke_to_active;

  assign stby = first_r[F_STBY];
  assign low_speed_select = first_r[F_LOW_SPEED_SELECT];
  assign sts_sel = first_r[F_STS_HI:F_STS_LO];
  assign ma_sel = first_r[F_MA_HI:F_MA_LO];
  assign medium_speed_select = second_r[F_MEDIUM_SPEED_SELECT];
  assign direct_transfer_enable = second_r[F_DIRECT_TRANSFER_ENABLE];
  assign sa_sel = second_r[F_SA_HI:F_SA_LO];
  assign in_active = (mode_r == PMC_ACT_HI) || (mode_r == PMC_ACT_MED);

  // Reserved bits are forced; writes only reach the writable mask.
  always_ff @(posedge clk) begin
    if (srst) begin
      first_r <= FIRST_RESET;
    end else if (reg_wr && reg_addr == ADDR_FIRST) begin
      first_r <= (reg_wdata & FIRST_WMASK) | FIRST_FIXED;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      second_r <= SECOND_RESET;
    end else if (reg_wr && reg_addr == ADDR_SECOND) begin
      second_r[7:5] <= SECOND_FIXED[7:5];
      second_r[4:2] <= reg_wdata[4:2];
      if (mode_r != PMC_SUBACT) begin
        second_r[F_SA_HI:F_SA_LO] <= reg_wdata[F_SA_HI:F_SA_LO];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= (reg_addr == ADDR_FIRST) ? first_r : second_r;
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = rdata_r;

  // Settle length is base shifted by the select; upper select bit saturates.
  always_comb begin
    settle_len = {1'b0, SETTLE_BASE} << (sts_sel[2] ? 3'h4 : {1'b0, sts_sel[1:0]});
  end

  always_comb begin
    mode_nxt = mode_r;
    woke_to_active = 1'b0;
    unique case (mode_r)
      PMC_ACT_HI, PMC_ACT_MED: begin
        if (sleep_req) begin
          if (direct_transfer_enable) begin
            if (mode_r == PMC_ACT_HI && !stby && medium_speed_select && !low_speed_select) begin
              mode_nxt = PMC_ACT_MED;
            end else if (mode_r == PMC_ACT_MED && !stby && !medium_speed_select && !low_speed_select) begin
              mode_nxt = PMC_ACT_HI;
            end else if (stby && timer_a_clock_select_bit && low_speed_select) begin
              mode_nxt = PMC_SUBACT;
            end
          end else if (!stby) begin
            mode_nxt = medium_speed_select ? PMC_SLP_MED : PMC_SLP_HI;
          end else begin
            mode_nxt = timer_a_clock_select_bit ? PMC_WATCH : PMC_STBY;
          end
        end
      end
      PMC_SUBACT: begin
        if (sleep_req) begin
          if (direct_transfer_enable) begin
            if (stby && timer_a_clock_select_bit && !low_speed_select) begin
              mode_nxt = medium_speed_select ? PMC_ACT_MED : PMC_ACT_HI;
            end
          end else begin
            mode_nxt = stby ? PMC_WATCH : PMC_SUBSLP;
          end
        end
      end
      PMC_SLP_HI, PMC_SLP_MED: begin
        if (wake_irq) begin
          mode_nxt = medium_speed_select ? PMC_ACT_MED : PMC_ACT_HI;
        end
      end
      PMC_SUBSLP: begin
        if (wake_irq) begin
          mode_nxt = PMC_SUBACT;
        end
      end
      PMC_WATCH: begin
        if (settle_r) begin
          if (settle_cnt_r >= settle_len - 18'h00001) begin
            mode_nxt = medium_speed_select ? PMC_ACT_MED : PMC_ACT_HI;
          end
        end else if (wake_irq) begin
          if (low_speed_select) begin
            mode_nxt = PMC_SUBACT;
          end else begin
            woke_to_active = 1'b1;
          end
        end
      end
      PMC_STBY: begin
        if (settle_r) begin
          if (settle_cnt_r >= settle_len - 18'h00001) begin
            mode_nxt = medium_speed_select ? PMC_ACT_MED : PMC_ACT_HI;
          end
        end else if (wake_irq) begin
          woke_to_active = 1'b1;
        end
      end
      default: mode_nxt = PMC_ACT_HI;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r <= PMC_ACT_HI;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // The oscillator runs while settling; the counter counts those states.
  always_ff @(posedge clk) begin
    if (srst) begin
      settle_r <= 1'b0;
      settle_cnt_r <= '0;
    end else if (woke_to_active) begin
      settle_r <= 1'b1;
      settle_cnt_r <= '0;
    end else if (settle_r && mode_nxt != mode_r) begin
      settle_r <= 1'b0;
      settle_cnt_r <= '0;
    end else if (settle_r) begin
      settle_cnt_r <= settle_cnt_r + 18'h00001;
    end
  end

  // Handling begins only on the edge that ends the wait, or any other wake.
  always_ff @(posedge clk) begin
    if (srst) begin
      exc_r <= 1'b0;
    end else begin
      exc_r <= wake_irq_exit(mode_r, mode_nxt);
    end
  end

  function automatic logic wake_irq_exit(input pmc_mode_t cur, input pmc_mode_t nxt);
    logic halted;
    halted = (cur == PMC_SLP_HI) || (cur == PMC_SLP_MED) || (cur == PMC_SUBSLP)
      || (cur == PMC_WATCH) || (cur == PMC_STBY);
    return halted && (nxt != cur);
  endfunction

  always_comb begin
    unique case (ma_sel)
      2'h0: ma_div = MA_DIV0;
      2'h1: ma_div = MA_DIV0 << 1;
      2'h2: ma_div = MA_DIV0 << 2;
      default: ma_div = MA_DIV0 << 3;
    endcase
  end

  always_comb begin
    unique case (sa_sel)
      2'h0: sa_div = SA_DIV0;
      2'h1: sa_div = SA_DIV0 >> 1;
      default: sa_div = SA_DIV0 >> 2;
    endcase
  end

  assign ns_div = second_r[F_NOISE_SAMPLE_RATE_SELECT] ? NS_FAST : NS_SLOW;

  // Ticks stand in for the real clock gates, which sit outside this block.
  pmc_divider u_med_div (
    .clk(clk),
    .srst(srst),
    .div_val(ma_div),
    .tick(medium_tick)
  );

  pmc_divider u_sub_div (
    .clk(clk),
    .srst(srst),
    .div_val(sa_div),
    .tick(subactive_tick)
  );

  pmc_divider u_ns_div (
    .clk(clk),
    .srst(srst),
    .div_val(ns_div),
    .tick(noise_sample_tick)
  );

  assign mode = mode_r;
  assign cpu_on_subclock = (mode_r == PMC_SUBACT) || (mode_r == PMC_SUBSLP);
  assign sys_osc_enable = in_active || (mode_r == PMC_SLP_HI) || (mode_r == PMC_SLP_MED)
    || settle_r;
  assign cpu_halted = !(in_active || mode_r == PMC_SUBACT);
  assign settling = settle_r;
  assign exception_start = exc_r;
endmodule

/* verif/pmc_top_properties.sv */
`timescale 1ns/10ps
// Watches only the top-level pins, so it holds with any internal encoding.
module pmc_top_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_rd,
  input wire logic [0:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic wake_irq,
  input wire logic [7:0] mode,
  input wire logic cpu_on_subclock,
  input wire logic sys_osc_enable,
  input wire logic cpu_halted,
  input wire logic settling,
  input wire logic exception_start
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  a_reset_mode: assert property ($past(srst) |-> mode == 8'h01 && !settling)
    else $error("mode or settling wrong after reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_first_rsv: assert property ($past(reg_rd) && $past(reg_addr) == 1'h0 |-> reg_rdata[2])
    else $error("reserved bit of first register reads zero");
  a_second_rsv: assert property ($past(reg_rd) && $past(reg_addr) == 1'h1
    |-> reg_rdata[7:5] == 3'h7)
    else $error("reserved bits of second register read zero");
  a_sleep_wake: assert property (mode == 8'h04 && wake_irq |=> mode == 8'h01)
    else $error("high-speed sleep did not wake to high-speed active");
  a_settle_mode: assert property (settling |-> sys_osc_enable && mode inside {8'h40, 8'h80})
    else $error("settling outside standby or watch or without oscillator");
  a_settle_exit: assert property ($fell(settling) |-> mode inside {8'h01, 8'h02}
    && exception_start)
    else $error("settle end not followed by exception start");
  a_no_exc_early: assert property (settling |-> !exception_start)
    else $error("exception start during settle wait");
  a_halted_cpu: assert property (mode inside {8'h04, 8'h08, 8'h20, 8'h40, 8'h80}
    |-> cpu_halted)
    else $error("cpu not halted in a halt mode");
  a_sub_clock: assert property (mode == 8'h10 |-> cpu_on_subclock)
    else $error("subactive mode not on subclock");
  c_standby: cover property (mode == 8'h80);
  c_settle_done: cover property ($fell(settling));
  c_subactive: cover property (mode == 8'h10);
endmodule

bind pmc_top pmc_top_properties u_props (.clk(clk), .srst(srst), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .wake_irq(wake_irq), .mode(mode),
  .cpu_on_subclock(cpu_on_subclock), .sys_osc_enable(sys_osc_enable),
  .cpu_halted(cpu_halted), .settling(settling), .exception_start(exception_start));

/* verif/pmc_cpu.sv */
`timescale 1ns/10ps
// Behavioural core: register cycles, sleep instructions and wake requests.
module pmc_cpu (
  input wire logic clk,
  output logic [0:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic sleep_req,
  output logic wake_irq,
  output logic timer_a_clock_select_bit
);
  initial begin
    reg_addr = 1'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_req = 1'b0;
    wake_irq = 1'b0;
    timer_a_clock_select_bit = 1'b0;
  end
  // Callers keep noise select clear, and keep the settle select at its shortest whenever they sleep.
  task automatic wr(input logic [0:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // One idle edge keeps back-to-back calls from lowering and raising a strobe at once.
    @(posedge clk);
  endtask
  task automatic rd(input logic [0:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  // The timer bit is a level, so it stays put after the sleep pulse.
  task automatic slp(input logic t);
    timer_a_clock_select_bit <= t;
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wake();
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    @(posedge clk);
  endtask
endmodule

/* verif/pmc_top_test.sv */
`timescale 1ns/10ps
module pmc_top_test;
  import pmc_pkg::*;
  logic clk;
  logic srst;
  logic [0:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic sleep_req;
  logic wake_irq;
  logic tma;
  logic [7:0] reg_rdata;
  logic [7:0] mode;
  wire [2:0] tk;
  logic [7:0] exp_q[$];
  logic rd_f = 1'b0;
  logic [7:0] d;
  int error_cnt = 0;
  int tests_run = 0;
  // First, second, timer bit, mode after sleep, mode after wake (00 means no wake).
  localparam logic [39:0] STEPS [9] = '{40'h00_00_00_04_01, 40'h00_04_00_08_02,
    40'h00_08_00_01_00, 40'h00_0c_00_02_00, 40'h80_00_00_80_01, 40'h80_00_01_40_01,
    40'h88_08_01_10_00, 40'h08_00_01_20_10, 40'h80_08_01_01_00};
  pmc_cpu cpu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .sleep_req(sleep_req), .wake_irq(wake_irq),
    .timer_a_clock_select_bit(tma));
  pmc_top DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
    .wake_irq(wake_irq), .timer_a_clock_select_bit(tma), .mode(mode),
    .cpu_on_subclock(), .sys_osc_enable(), .cpu_halted(), .settling(),
    .exception_start(), .medium_tick(tk[0]), .subactive_tick(tk[1]),
    .noise_sample_tick(tk[2]));
  task automatic complete_run();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (e !== g) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic rd(input logic [0:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cpu.rd(a);
  endtask
  // Bounded wait for a mode; running out of cycles ends the run as a failure.
  task automatic wm(input logic [7:0] e, input int lim, output int n);
    n = 0;
    #1;
    while (mode !== e && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("mode", e, mode);
    if (n >= lim) complete_run();
    @(posedge clk);
  endtask
  // Measures the spacing of two tick pulses; a missing tick ends the run as a failure.
  task automatic per(input int k, input logic [7:0] e);
    int c;
    c = 0;
    @(posedge clk);
    #1;
    while (!tk[k] && c < 300) begin
      @(posedge clk);
      #1;
      c++;
    end
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (!tk[k] && c < 300);
    chk("tick", e, 8'(c));
    if (c >= 300) complete_run();
    @(posedge clk);
  endtask
  // Read data stand for one cycle only, so the oldest note is compared at once.
  always @(negedge clk) begin
    if (rd_f && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), reg_rdata);
    rd_f = reg_rd;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    int n;
    srst = 1'b1;
    void'($urandom(32'h7dd5));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd(1'h0, FIRST_RESET);
    rd(1'h1, SECOND_RESET);
    per(0, 8'h80);
    per(1, 8'h08);
    per(2, 8'h10);
    repeat (4) begin
      d = 8'($urandom);
      cpu.wr(1'h0, d);
      rd(1'h0, (d & FIRST_WMASK) | FIRST_FIXED);
      d = 8'($urandom) & 8'hef;
      cpu.wr(1'h1, d);
      rd(1'h1, (d & SECOND_WMASK) | SECOND_FIXED);
    end
    for (int i = 0; i < 9; i++) begin
      if (i == 7) begin
        cpu.wr(1'h1, 8'h0b);
        rd(1'h1, 8'he8);
      end
      cpu.wr(1'h0, STEPS[i][39:32]);
      cpu.wr(1'h1, STEPS[i][31:24]);
      cpu.slp(STEPS[i][16]);
      wm(STEPS[i][15:8], 4, n);
      if (STEPS[i][7:0] !== 8'h00) begin
        cpu.wake();
        wm(STEPS[i][7:0], 9000, n);
        // The idle edge after the wake edge is one of the 8192 settle states; the wake edge itself is not.
        if (|STEPS[i][15:14]) chk("settle", 8'h01, {7'h0, n == 8191});
      end
    end
    repeat (3) @(posedge clk);
    chk("queue", 8'h00, 8'(exp_q.size()));
    complete_run();
  end
endmodule
